// ---- src/dect_top.sv ----
// Dual event counter and timer with a classic Wishbone register slave.
//
// Operation
// - Two counter units; unit_select picks unit 0 or 1 for access.
// - All settings, values and status are stored per unit, except the shared unit select, interrupt status and mask.
// - Count advances on the chosen increment source from the list.
// - Qualifier picks level low, level high, falling, rising or any edge.
// - Begin event fires when counted occurrences reach start_delay_count.
// - Finish event fires when counted occurrences reach end_duration_count.
// - Start trigger and reset source are exclusive; choosing one clears other.
// - Selected start trigger, qualified, starts the unit from zero.
// - Selected reset signal, qualified, resets the unit count.
// - Live count of selected unit is readable at any time.
// - On reset the prior count is captured into captured_count.
// - Operating state of selected unit is readable.
`timescale 1ns/1ps

module dect_top (
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave.
  input  wire dect_pkg::dect_wb_req_t wb_req_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // Camera signals.
  input  wire dect_pkg::dect_sig_in_t sig_i,
  // Events and interrupt.
  output logic [1:0]                 begin_event_o,
  output logic [1:0]                 finish_event_o,
  output logic                       irq_o
);

  dect_pkg::dect_st_t         r_reg;
  dect_pkg::dect_st_t         r_next;
  logic [dect_pkg::NSIG-1:0]  sig_now;
  logic [1:0]                 inc_hit;
  logic [1:0]                 trg_hit;
  logic [1:0]                 rst_hit;
  logic                       take;

  localparam int SRC_LSB_W  = dect_pkg::SRC_LSB;
  localparam int QUAL_LSB_W = dect_pkg::QUAL_LSB;

  // Unit events feed back from registered pulses, so a unit can count the
  // other's events without a combinational loop, one cycle late.
  assign sig_now = {sig_i.frame_trigger_pending, sig_i.exposure_end,
                    sig_i.exposure_start, sig_i.lut_cell_output,
                    r_reg.u[1].finish_p, r_reg.u[0].finish_p,
                    r_reg.u[1].begin_p, r_reg.u[0].begin_p,
                    sig_i.software_output, sig_i.line,
                    sig_i.microsecond_tick, 1'b0};

  function automatic logic qualify(
    input logic [dect_pkg::NSIG-1:0] now,
    input logic [dect_pkg::NSIG-1:0] prev,
    input dect_pkg::dect_src_t       s,
    input dect_pkg::dect_qual_t      q
  );
    logic c;
    logic p;
    logic hit;
    c = now[s];
    p = prev[s];
    case (q)
      dect_pkg::Q_LEVEL_LOW:  hit = !c;
      dect_pkg::Q_LEVEL_HIGH: hit = c;
      dect_pkg::Q_FALL:       hit = p && !c;
      dect_pkg::Q_RISE:       hit = !p && c;
      dect_pkg::Q_ANY:        hit = p ^ c;
      default:                hit = 1'b0;
    endcase
    return hit && (s != dect_pkg::SRC_OFF);
  endfunction

  // Codes beyond the list are stored as off.
  function automatic dect_pkg::dect_src_t src_fix(input logic [4:0] v);
    return (v > dect_pkg::SRC_FRAME_PEND) ? dect_pkg::SRC_OFF
                                          : dect_pkg::dect_src_t'(v);
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  sel
  );
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction

  genvar gu;
  generate
    for (gu = 0; gu < 2; gu++) begin : g_unit
      assign inc_hit[gu] = qualify(sig_now, r_reg.prev,
                                   r_reg.u[gu].inc_src,
                                   r_reg.u[gu].inc_q);
      assign trg_hit[gu] = qualify(sig_now, r_reg.prev,
                                   r_reg.u[gu].trg_src,
                                   r_reg.u[gu].trg_q);
      assign rst_hit[gu] = qualify(sig_now, r_reg.prev,
                                   r_reg.u[gu].rst_src,
                                   r_reg.u[gu].rst_q);
    end
  endgenerate

  assign take = wb_req_i.cyc && wb_req_i.stb && !r_reg.ack;

  always_comb begin
    dect_pkg::dect_unit_t cur;
    logic [31:0]          rd;
    logic [31:0]          wv;
    logic [31:0]          nxt;
    logic                 wr;
    logic [3:0]           ev;
    cur    = r_reg.u[r_reg.sel];
    rd     = 32'h0;
    nxt    = 32'h0;
    wv     = 32'h0;
    ev     = 4'h0;
    r_next = r_reg;
    wr     = take && wb_req_i.we;

    // Per-unit counting; reset wins over trigger and increment; trigger acts only outside active, increment only in it.
    for (int i = 0; i < 2; i++) begin
      r_next.u[i].begin_p  = 1'b0;
      r_next.u[i].finish_p = 1'b0;
      nxt = r_reg.u[i].count + 32'h1;
      case (r_reg.u[i].state)
        dect_pkg::ST_IDLE: begin
          if (r_reg.u[i].inc_src != dect_pkg::SRC_OFF) begin
            r_next.u[i].state =
              (r_reg.u[i].trg_src != dect_pkg::SRC_OFF) ?
              dect_pkg::ST_TRIG_WAIT : dect_pkg::ST_ACTIVE;
          end
        end
        dect_pkg::ST_TRIG_WAIT, dect_pkg::ST_COMPLETED,
        dect_pkg::ST_OVERFLOW: begin
          if (trg_hit[i]) begin
            r_next.u[i].count = 32'h0;
            r_next.u[i].state = dect_pkg::ST_ACTIVE;
          end
        end
        dect_pkg::ST_ACTIVE: begin
          if (inc_hit[i]) begin
            if (r_reg.u[i].count == 32'hffff_ffff) begin
              r_next.u[i].state = dect_pkg::ST_OVERFLOW;
            end else begin
              r_next.u[i].count = nxt;
              if (nxt == r_reg.u[i].delay) begin
                r_next.u[i].begin_p = 1'b1;
              end
              if (nxt == r_reg.u[i].duration) begin
                r_next.u[i].finish_p = 1'b1;
                r_next.u[i].state    = dect_pkg::ST_COMPLETED;
              end
            end
          end
        end
        default: r_next.u[i].state = dect_pkg::ST_IDLE;
      endcase
      if (rst_hit[i] && r_reg.u[i].state != dect_pkg::ST_IDLE) begin
        r_next.u[i].captured = r_reg.u[i].count;
        r_next.u[i].count    = 32'h0;
        r_next.u[i].state    = dect_pkg::ST_ACTIVE;
        r_next.u[i].begin_p  = 1'b0;
        r_next.u[i].finish_p = 1'b0;
      end
    end
    r_next.prev = sig_now;

    // Register read image of the selected unit.
    case (wb_req_i.adr)
      dect_pkg::OFS_SELECT:   rd = {31'h0, r_reg.sel};
      dect_pkg::OFS_INC_CFG:  rd = {21'h0, cur.inc_q, 3'h0, cur.inc_src};
      dect_pkg::OFS_TRG_CFG:  rd = {21'h0, cur.trg_q, 3'h0, cur.trg_src};
      dect_pkg::OFS_RST_CFG:  rd = {21'h0, cur.rst_q, 3'h0, cur.rst_src};
      dect_pkg::OFS_DELAY:    rd = cur.delay;
      dect_pkg::OFS_DURATION: rd = cur.duration;
      dect_pkg::OFS_LIVE:     rd = cur.count;
      dect_pkg::OFS_CAPTURED: rd = cur.captured;
      dect_pkg::OFS_STATE:    rd = {27'h0, cur.state};
      dect_pkg::OFS_IRQ_STAT: rd = {28'h0, r_reg.irq_stat};
      dect_pkg::OFS_IRQ_MASK: rd = {28'h0, r_reg.irq_mask};
      default:                rd = 32'h0;
    endcase
    wv = merge(rd, wb_req_i.dat, wb_req_i.sel);

    if (wr) begin
      case (wb_req_i.adr)
        dect_pkg::OFS_SELECT: r_next.sel = wv[0];
        dect_pkg::OFS_INC_CFG: begin
          r_next.u[r_reg.sel].inc_src = src_fix(wv[SRC_LSB_W +: 5]);
          r_next.u[r_reg.sel].inc_q   =
            dect_pkg::dect_qual_t'(wv[QUAL_LSB_W +: 3]);
        end
        dect_pkg::OFS_TRG_CFG: begin
          r_next.u[r_reg.sel].trg_src = src_fix(wv[SRC_LSB_W +: 5]);
          r_next.u[r_reg.sel].trg_q   =
            dect_pkg::dect_qual_t'(wv[QUAL_LSB_W +: 3]);
          if (src_fix(wv[SRC_LSB_W +: 5]) != dect_pkg::SRC_OFF) begin
            r_next.u[r_reg.sel].rst_src = dect_pkg::SRC_OFF;
          end
        end
        dect_pkg::OFS_RST_CFG: begin
          r_next.u[r_reg.sel].rst_src = src_fix(wv[SRC_LSB_W +: 5]);
          r_next.u[r_reg.sel].rst_q   =
            dect_pkg::dect_qual_t'(wv[QUAL_LSB_W +: 3]);
          if (src_fix(wv[SRC_LSB_W +: 5]) != dect_pkg::SRC_OFF) begin
            r_next.u[r_reg.sel].trg_src = dect_pkg::SRC_OFF;
          end
        end
        dect_pkg::OFS_DELAY:    r_next.u[r_reg.sel].delay    = wv;
        dect_pkg::OFS_DURATION: r_next.u[r_reg.sel].duration = wv;
        dect_pkg::OFS_CAPTURED: r_next.u[r_reg.sel].captured = wv;
        dect_pkg::OFS_IRQ_MASK: r_next.irq_mask = wv[3:0];
        default: ;
      endcase
    end

    // A write of one clears a status bit, but a new event in the same
    // cycle wins so no event is lost.
    ev[dect_pkg::IRQ_U0_BEGIN]  = r_next.u[0].begin_p;
    ev[dect_pkg::IRQ_U0_FINISH] = r_next.u[0].finish_p;
    ev[dect_pkg::IRQ_U1_BEGIN]  = r_next.u[1].begin_p;
    ev[dect_pkg::IRQ_U1_FINISH] = r_next.u[1].finish_p;
    if (wr && wb_req_i.adr == dect_pkg::OFS_IRQ_STAT) begin
      r_next.irq_stat = r_reg.irq_stat & ~wv[3:0];
    end
    r_next.irq_stat = r_next.irq_stat | ev;

    r_next.ack   = take;
    r_next.rdata = (take && !wb_req_i.we) ? rd : 32'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg          <= '0;
      r_reg.irq_mask <= dect_pkg::RST_IRQ_MASK;
      for (int i = 0; i < 2; i++) begin
        r_reg.u[i].state    <= dect_pkg::ST_IDLE;
        r_reg.u[i].delay    <= dect_pkg::RST_DELAY;
        r_reg.u[i].duration <= dect_pkg::RST_DURATION;
      end
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_dat_o       = r_reg.rdata;
  assign wb_ack_o       = r_reg.ack;
  assign begin_event_o  = {r_reg.u[1].begin_p, r_reg.u[0].begin_p};
  assign finish_event_o = {r_reg.u[1].finish_p, r_reg.u[0].finish_p};
  assign irq_o          = |(r_reg.irq_stat & r_reg.irq_mask);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take_rd(logic [7:0] a);
    take && !wb_req_i.we && wb_req_i.adr == a;
  endsequence

  sequence s_u0_count;
    r_reg.u[0].state == dect_pkg::ST_ACTIVE && inc_hit[0] && !rst_hit[0] &&
    r_reg.u[0].count != 32'hffff_ffff;
  endsequence

  // A software write of the captured field in the same cycle takes over the
  // captured value, so such cycles are left out of the reset check.
  sequence s_u1_reset;
    rst_hit[1] && r_reg.u[1].state != dect_pkg::ST_IDLE &&
    !(take && wb_req_i.we && wb_req_i.adr == dect_pkg::OFS_CAPTURED);
  endsequence

  sequence s_u1_cleared;
    r_reg.u[1].captured == $past(r_reg.u[1].count) &&
    r_reg.u[1].count == 32'h0 && r_reg.u[1].state == dect_pkg::ST_ACTIVE;
  endsequence

  sequence s_u0_restart;
    r_reg.u[0].state != dect_pkg::ST_IDLE &&
    r_reg.u[0].state != dect_pkg::ST_ACTIVE && trg_hit[0] && !rst_hit[0];
  endsequence

  // Bus and readback.
  a_ack_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  a_live_read: assert property (
    s_take_rd(dect_pkg::OFS_LIVE) |=>
    wb_dat_o == $past(r_reg.u[r_reg.sel].count))
    else $error("live count readback wrong");
  a_state_read: assert property (
    s_take_rd(dect_pkg::OFS_STATE) |=>
    wb_dat_o[4:0] == $past(r_reg.u[r_reg.sel].state))
    else $error("unit state readback wrong");
  a_src_exclusive: assert property (
    !(r_reg.u[0].trg_src != dect_pkg::SRC_OFF &&
      r_reg.u[0].rst_src != dect_pkg::SRC_OFF) &&
    !(r_reg.u[1].trg_src != dect_pkg::SRC_OFF &&
      r_reg.u[1].rst_src != dect_pkg::SRC_OFF))
    else $error("trigger and reset both active");

  // Counting, events and control sources.
  a_begin_event: assert property (
    s_u0_count and (r_reg.u[0].count + 32'h1 == r_reg.u[0].delay) |=>
    begin_event_o[0] ##1 !begin_event_o[0])
    else $error("begin event missing");
  a_finish_event: assert property (
    s_u0_count and (r_reg.u[0].count + 32'h1 == r_reg.u[0].duration) |=>
    finish_event_o[0] && r_reg.u[0].state == dect_pkg::ST_COMPLETED)
    else $error("finish event missing");
  a_count_step: assert property (
    s_u0_count |=> r_reg.u[0].count == $past(r_reg.u[0].count) + 32'h1)
    else $error("count did not advance");
  a_u1_step: assert property (
    r_reg.u[1].state == dect_pkg::ST_ACTIVE && inc_hit[1] && !rst_hit[1] &&
    r_reg.u[1].count != 32'hffff_ffff |=>
    r_reg.u[1].count == $past(r_reg.u[1].count) + 32'h1)
    else $error("unit 1 count did not advance");
  a_reset_capture: assert property (
    s_u1_reset |=> s_u1_cleared)
    else $error("reset capture wrong");
  a_trigger_start: assert property (
    s_u0_restart |=>
    r_reg.u[0].state == dect_pkg::ST_ACTIVE && r_reg.u[0].count == 32'h0)
    else $error("trigger did not start unit");
  a_off_hold: assert property (
    r_reg.u[0].inc_src == dect_pkg::SRC_OFF && !rst_hit[0] && !trg_hit[0]
    |=> $stable(r_reg.u[0].count))
    else $error("count moved with source off");
  a_unit_indep: assert property (
    wb_req_i.we && take && r_reg.sel && wb_req_i.adr == dect_pkg::OFS_DELAY
    |=> $stable(r_reg.u[0].delay))
    else $error("write leaked to other unit");

  // A pulse that left no status bit behind would be an interrupt lost.
  a_status_set: assert property (
    !(begin_event_o[0] && !r_reg.irq_stat[dect_pkg::IRQ_U0_BEGIN]) &&
    !(finish_event_o[0] && !r_reg.irq_stat[dect_pkg::IRQ_U0_FINISH]))
    else $error("event did not set its status bit");

endmodule // dect_top

// ---- src/dect_pkg.sv ----
// Package for the dual event counter and timer: offsets, codes and types.
package dect_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_SELECT   = 8'h00;
  localparam logic [7:0] OFS_INC_CFG  = 8'h04;
  localparam logic [7:0] OFS_TRG_CFG  = 8'h08;
  localparam logic [7:0] OFS_RST_CFG  = 8'h0c;
  localparam logic [7:0] OFS_DELAY    = 8'h10;
  localparam logic [7:0] OFS_DURATION = 8'h14;
  localparam logic [7:0] OFS_LIVE     = 8'h18;
  localparam logic [7:0] OFS_CAPTURED = 8'h1c;
  localparam logic [7:0] OFS_STATE    = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

  // Field positions inside the source configuration words.
  localparam int SRC_LSB  = 0;
  localparam int QUAL_LSB = 8;

  // Interrupt status bit positions.
  localparam int IRQ_U0_BEGIN  = 0;
  localparam int IRQ_U0_FINISH = 1;
  localparam int IRQ_U1_BEGIN  = 2;
  localparam int IRQ_U1_FINISH = 3;

  // Values after reset.
  localparam logic [31:0] RST_DELAY    = 32'h0000_0000;
  localparam logic [31:0] RST_DURATION = 32'h0000_0000;
  localparam logic [3:0]  RST_IRQ_MASK = 4'h0;

  localparam int NSIG = 19;

  typedef enum logic [4:0] {
    SRC_OFF = 5'h00, SRC_TICK = 5'h01,
    SRC_LINE0 = 5'h02, SRC_LINE1 = 5'h03, SRC_LINE2 = 5'h04,
    SRC_LINE3 = 5'h05, SRC_SWOUT0 = 5'h06, SRC_SWOUT1 = 5'h07,
    SRC_SWOUT2 = 5'h08, SRC_SWOUT3 = 5'h09, SRC_U0_BEGIN = 5'h0a,
    SRC_U1_BEGIN = 5'h0b, SRC_U0_FINISH = 5'h0c, SRC_U1_FINISH = 5'h0d,
    SRC_LUT0 = 5'h0e, SRC_LUT1 = 5'h0f, SRC_EXP_START = 5'h10,
    SRC_EXP_END = 5'h11, SRC_FRAME_PEND = 5'h12
  } dect_src_t;

  typedef enum logic [2:0] {
    Q_LEVEL_LOW = 3'h0, Q_LEVEL_HIGH = 3'h1, Q_FALL = 3'h2,
    Q_RISE = 3'h3, Q_ANY = 3'h4
  } dect_qual_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_TRIG_WAIT = 5'h02, ST_ACTIVE = 5'h04,
    ST_COMPLETED = 5'h08, ST_OVERFLOW = 5'h10
  } dect_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } dect_wb_req_t;

  typedef struct packed {
    logic       microsecond_tick;
    logic [3:0] line;
    logic [3:0] software_output;
    logic [1:0] lut_cell_output;
    logic       exposure_start;
    logic       exposure_end;
    logic       frame_trigger_pending;
  } dect_sig_in_t;

  typedef struct packed {
    dect_src_t   inc_src;
    dect_qual_t  inc_q;
    dect_src_t   trg_src;
    dect_qual_t  trg_q;
    dect_src_t   rst_src;
    dect_qual_t  rst_q;
    logic [31:0] delay;
    logic [31:0] duration;
    logic [31:0] count;
    logic [31:0] captured;
    dect_state_t state;
    logic        begin_p;
    logic        finish_p;
  } dect_unit_t;

  typedef struct packed {
    logic                  sel;
    dect_unit_t [1:0]      u;
    logic [NSIG-1:0]       prev;
    logic [3:0]            irq_stat;
    logic [3:0]            irq_mask;
    logic                  ack;
    logic [31:0]           rdata;
  } dect_st_t;

endpackage

// ---- verification/dect_top_bench.sv ----
// Self-checking bench for the dual event counter and timer.
`timescale 1ns/1ps

module dect_top_bench;
  logic                   clk_i;
  logic                   rst_i;
  dect_pkg::dect_wb_req_t req;
  dect_pkg::dect_sig_in_t sig;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o;
  logic [1:0]             begin_event_o;
  logic [1:0]             finish_event_o;
  logic                   irq_o;
  logic [3:0]             lines;
  logic [31:0]            rnd = 32'h64ce;
  logic [31:0]            rd;
  int                     n_errors;
  int                     checks;
  int                     cycles;
  int                     nb[2];
  int                     nf[2];
  int                     exp1;
  int                     d;
  int                     k;
  int                     qexp[5] = '{3, 3, 1, 1, 2};

  // Noise on the unused camera signals keeps each of those inputs toggling.
  assign sig = '{microsecond_tick: rnd[0], line: lines,
                 software_output: rnd[4:1], lut_cell_output: rnd[6:5],
                 exposure_start: rnd[7], exposure_end: rnd[8],
                 frame_trigger_pending: rnd[9]};

  dect_top i_dut (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .wb_req_i       (req),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .sig_i          (sig),
    .begin_event_o  (begin_event_o),
    .finish_event_o (finish_event_o),
    .irq_o          (irq_o)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] cfg(input logic [4:0] s,
                                      input logic [2:0] q);
    logic [31:0] c;
    c = 32'h0000_0000;
    c[4:0] = s;
    c[10:8] = q;
    return c;
  endfunction

  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask

  task automatic wb_cycle(input logic we, input logic [7:0] a,
                          input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: wd};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] q;
    wb_cycle(1'b1, a, wd, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb_cycle(1'b0, a, 32'h0000_0000, rd);
    check(rd, exp);
  endtask

  // Each pulse is high one cycle, then low for a random gap of 1 to 3.
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge clk_i);
      lines[b] <= 1'b1;
      @(posedge clk_i);
      lines[b] <= 1'b0;
      repeat (rnd[1:0] % 3) @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    rnd <= lfsr_next(rnd);
    cycles++;
    if (!rst_i) begin
      for (int u = 0; u < 2; u++) begin
        if (begin_event_o[u] === 1'b1) nb[u]++;
        if (finish_event_o[u] === 1'b1) nf[u]++;
      end
    end
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    rst_i = 1'b1;
    req = '0;
    lines = 4'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(dect_pkg::OFS_STATE, 32'h1);
    rdc(dect_pkg::OFS_CAPTURED, 32'h0);
    rdc(dect_pkg::OFS_DELAY, 32'h0);
    rdc(8'h40, 32'h0);
    wr(dect_pkg::OFS_LIVE, 32'h55);
    rdc(dect_pkg::OFS_LIVE, 32'h0);
    // Unit 0 counts rising edges of line 0 up to its finish count.
    d = 1 + rnd[3:0] % 3;
    wr(dect_pkg::OFS_DELAY, d);
    wr(dect_pkg::OFS_DURATION, d + 2);
    wr(dect_pkg::OFS_INC_CFG, cfg(5'h02, 3'h3));
    pulse(0, d + 3);
    check(nb[0], 1);
    check(nf[0], 1);
    rdc(dect_pkg::OFS_LIVE, d + 2);
    rdc(dect_pkg::OFS_STATE, 32'h8);
    // Unit 1 sees every qualifier on line 2; counts are held while off.
    wr(dect_pkg::OFS_SELECT, 32'h1);
    rdc(dect_pkg::OFS_LIVE, 32'h0);
    wr(dect_pkg::OFS_DELAY, 32'h0);
    exp1 = 0;
    for (int q = 0; q < 5; q++) begin
      @(posedge clk_i);
      lines[2] <= (q == 0);
      repeat (3) @(posedge clk_i);
      wr(dect_pkg::OFS_INC_CFG, cfg(5'h04, 3'(q)));
      repeat (3) @(posedge clk_i) lines[2] <= (q != 0);
      @(posedge clk_i);
      lines[2] <= (q == 0);
      repeat (3) @(posedge clk_i);
      wr(dect_pkg::OFS_INC_CFG, cfg(5'h00, 3'h3));
      exp1 += qexp[q];
      rdc(dect_pkg::OFS_LIVE, exp1);
    end
    @(posedge clk_i);
    lines[2] <= 1'b0;
    pulse(2, 2);
    rdc(dect_pkg::OFS_LIVE, exp1);
    // Reset source displaces the trigger source and captures the count.
    wr(dect_pkg::OFS_INC_CFG, cfg(5'h05, 3'h3));
    wr(dect_pkg::OFS_TRG_CFG, cfg(5'h02, 3'h3));
    wr(dect_pkg::OFS_RST_CFG, cfg(5'h03, 3'h3));
    rdc(dect_pkg::OFS_TRG_CFG, 32'h0300);
    k = 1 + rnd[5:2] % 4;
    pulse(3, k);
    exp1 += k;
    rdc(dect_pkg::OFS_LIVE, exp1);
    pulse(1, 1);
    rdc(dect_pkg::OFS_CAPTURED, exp1);
    rdc(dect_pkg::OFS_LIVE, 32'h0);
    wr(dect_pkg::OFS_TRG_CFG, cfg(5'h02, 3'h3));
    rdc(dect_pkg::OFS_RST_CFG, 32'h0300);
    // Interrupt from the unit 0 events: mask on, clear one, mask off, clear the other.
    wr(dect_pkg::OFS_IRQ_MASK, 32'h3);
    @(posedge clk_i);
    check(irq_o, 1'b1);
    rdc(dect_pkg::OFS_IRQ_STAT, 32'h3);
    wr(dect_pkg::OFS_IRQ_STAT, 32'h1);
    rdc(dect_pkg::OFS_IRQ_STAT, 32'h2);
    check(irq_o, 1'b1);
    wr(dect_pkg::OFS_IRQ_MASK, 32'h0);
    @(posedge clk_i);
    check(irq_o, 1'b0);
    wr(dect_pkg::OFS_IRQ_STAT, 32'h2);
    rdc(dect_pkg::OFS_IRQ_STAT, 32'h0);
    // A trigger restarts the completed unit 0 from zero.
    wr(dect_pkg::OFS_SELECT, 32'h0);
    wr(dect_pkg::OFS_TRG_CFG, cfg(5'h03, 3'h3));
    pulse(1, 1);
    rdc(dect_pkg::OFS_LIVE, 32'h0);
    pulse(0, 1);
    rdc(dect_pkg::OFS_LIVE, 32'h1);
    rdc(dect_pkg::OFS_DELAY, d);
    check(nb[1], 0);
    check(nf[1], 0);
    report_and_stop();
  end
endmodule // dect_top_bench
